// [open_fault_regs.vh]
// offsets, field positions and timing counts of the open-load and thermal fault logic
`ifndef OPEN_FAULT_REGS_VH
`define OPEN_FAULT_REGS_VH
// register offsets (word addresses on the plain register port)
`define CONTROL_REG_ONE_ADDR     4'h1
`define CONTROL_REG_THREE_ADDR   4'h3
`define CONTROL_REG_FOUR_ADDR    4'h4
`define STATUS_REG_ADDR          4'h8
// field positions
`define PASSIVE_OPEN_ENABLE_BIT  0
`define CLEAR_ERRORS_BIT         0
`define OVERTEMP_RECOVERY_BIT    1
`define ACTIVE_OPEN_ENABLE_BIT   0
`define ST_FAULT_BIT             0
`define ST_OUT1_OPEN_BIT         1
`define ST_OUT2_OPEN_BIT         2
`define ST_OVERTEMP_BIT          3
`define ST_ACTIVE_OPEN_BIT       4
`define ST_PASSIVE_BUSY_BIT      5
// timing: times in ns at a 10 ns clock
`define CLK_PERIOD_NS            10
`define DISABLE_SETTLE_NS        200000
`define OPEN_TEST_DURATION_NS    300000
`define PHASE_TIME_NS            100000
`define DISABLE_SETTLE_CYC       (`DISABLE_SETTLE_NS / `CLK_PERIOD_NS)
`define OPEN_TEST_DURATION_CYC   (`OPEN_TEST_DURATION_NS / `CLK_PERIOD_NS)
`define PHASE_CYC                (`PHASE_TIME_NS / `CLK_PERIOD_NS)
// consecutive active open events needed before a report
`define ACTIVE_OPEN_COUNT        2'h3
`endif

// [open_fault_logic.v]
// open-load diagnostics and thermal shutdown logic of an h-bridge driver
`timescale 1ns/1ns
`default_nettype none
`include "open_fault_regs.vh"

module open_fault_logic #(
   parameter SERIAL_VARIANT = 1,
   parameter DISABLE_SETTLE = `DISABLE_SETTLE_CYC,
   parameter TEST_DURATION  = `OPEN_TEST_DURATION_CYC,
   parameter PHASE_LEN      = `PHASE_CYC,
   parameter CNT_W          = 16
) (
   // clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // register port
   input  wire [3:0]  addr,
   input  wire [7:0]  wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [7:0]  rdata,
   // host pins
   input  wire        disable_pin,
   input  wire        sleep_pin_n,
   input  wire        open_load_cfg_pin_n,
   // motor state and control mode (0 phase/enable, 1 pwm, 2 independent)
   input  wire        motor_energized,
   input  wire [1:0]  control_mode,
   // analog comparators and events
   input  wire [1:0]  pullup_open_comparator,
   input  wire [1:0]  pulldown_open_comparator,
   input  wire        pwm_cycle_end,
   input  wire        overshoot_seen,
   input  wire        overtemp_hot,
   input  wire        overtemp_cool,
   // analog controls
   output reg  [1:0]  pullup_source_en,
   output reg  [1:0]  pulldown_source_en,
   output reg         bridge_enable,
   output reg         high_side_recirc,
   output reg         charge_pump_en,
   // error pin, open drain
   output wire        error_pin_n_o,
   output wire        error_pin_n_oe
);

   localparam ST_IDLE   = 3'h0;
   localparam ST_SETTLE = 3'h1;
   localparam ST_PU     = 3'h2;
   localparam ST_PD     = 3'h3;
   localparam ST_WAIT   = 3'h4;

   // true on the last cycle of a pull-up or pull-down phase; the phase
   // step and the flag latch must agree on that cycle, so both use this
   function phase_end;
      input [CNT_W-1:0] count;
      begin
         phase_end = (count == PHASE_LEN[CNT_W-1:0] - 1'b1);
      end
   endfunction

   // synchronisers for pins and asynchronous comparators
   // only the second stage is read, so a metastable first stage never
   // reaches the sequencer or the flag latches
   reg [7:0] s1_q;
   reg [7:0] s2_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
      end else begin
         s1_q <= {overtemp_cool, overtemp_hot, pulldown_open_comparator, pullup_open_comparator,
                  sleep_pin_n, disable_pin};
         s2_q <= s1_q;
      end
   end
   wire       dis_s   = s2_q[0];
   wire       sleep_s = s2_q[1];
   wire [1:0] pu_s    = s2_q[3:2];
   wire [1:0] pd_s    = s2_q[5:4];
   wire       hot_s   = s2_q[6];
   wire       cool_s  = s2_q[7];

   // config pin passes its own pair; it is read only at power-up or sleep exit
   reg cfg1_q;
   reg cfg2_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg1_q <= 1'b0;
         cfg2_q <= 1'b0;
      end else begin
         cfg1_q <= open_load_cfg_pin_n;
         cfg2_q <= cfg1_q;
      end
   end

   // sleep exit detection; leaving reset with the sleep pin high also counts as a wake
   reg sleep_d_q;
   reg woke_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_d_q <= 1'b0;
         woke_q    <= 1'b0;
      end else begin
         sleep_d_q <= sleep_s;
         woke_q    <= sleep_s & ~sleep_d_q;
      end
   end
   wire sleep_now = ~sleep_s;                   // sleep held low acts as reset for as long as it stays low

   // decoded register writes
   wire wr1 = wr && (addr == `CONTROL_REG_ONE_ADDR);
   wire wr3 = wr && (addr == `CONTROL_REG_THREE_ADDR);
   wire wr4 = wr && (addr == `CONTROL_REG_FOUR_ADDR);
   wire clear_cmd = (wr3 && wdata[`CLEAR_ERRORS_BIT]) || sleep_now;

   // latched pin config and control bits
   reg cfg_high_q;
   reg passive_open_enable_q;
   reg active_open_enable_q;
   reg overtemp_recovery_sel_q;
   reg [2:0] state_q;
   reg [CNT_W-1:0] cnt_q;
   reg [CNT_W-1:0] tot_q;
   reg [1:0] pu_hit_q;
   wire [1:0] open_flag_q;
   reg [1:0] ola_cnt_q;
   reg active_open_q;
   reg overtemp_flag_q;
   reg overtemp_off_q;

   wire test_done = (state_q != ST_IDLE) && (tot_q == TEST_DURATION[CNT_W-1:0] - 1'b1);
   wire abort = (state_q != ST_IDLE) && (!dis_s || motor_energized);
   wire pin_start = !SERIAL_VARIANT && woke_q && !cfg2_q && dis_s && !motor_energized;
   // a start is refused while the pin is low or the motor is energized
   wire start = SERIAL_VARIANT ? (wr1 && wdata[`PASSIVE_OPEN_ENABLE_BIT] && dis_s && !motor_energized)
                               : pin_start;

   // control bits, held by the serial variant and strapped in the pin variant
   // the enable bit is only set by an accepted start; a refused write would
   // otherwise leave it stuck at 1 with no test running to clear it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_high_q              <= 1'b0;
         passive_open_enable_q   <= 1'b0;
         active_open_enable_q    <= 1'b0;
         overtemp_recovery_sel_q <= SERIAL_VARIANT ? 1'b0 : 1'b1;
      end else if (sleep_now) begin
         passive_open_enable_q   <= 1'b0;
         active_open_enable_q    <= 1'b0;
         overtemp_recovery_sel_q <= SERIAL_VARIANT ? 1'b0 : 1'b1;
      end else begin
         if (woke_q)
            cfg_high_q <= cfg2_q;
         if (SERIAL_VARIANT) begin
            if (start && state_q == ST_IDLE)
               passive_open_enable_q <= 1'b1;
            else if (abort || test_done)
               passive_open_enable_q <= 1'b0;
            if (wr4)
               active_open_enable_q <= wdata[`ACTIVE_OPEN_ENABLE_BIT];
            if (wr3)
               overtemp_recovery_sel_q <= wdata[`OVERTEMP_RECOVERY_BIT];
         end else begin
            if (woke_q)
               active_open_enable_q <= ~cfg2_q;
            if (pin_start)
               passive_open_enable_q <= 1'b1;
            else if (abort || test_done)
               passive_open_enable_q <= 1'b0;
         end
      end
   end

   // passive test sequencer: settle (pin variant only), pull-up phase, pull-down phase, hold to duration
   // the total counter runs across all phases, so the duration bounds the
   // whole test whatever the phase lengths are
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= ST_IDLE;
         cnt_q    <= {CNT_W{1'b0}};
         tot_q    <= {CNT_W{1'b0}};
         pu_hit_q <= 2'h0;
      end else if (sleep_now || abort || test_done) begin
         state_q  <= ST_IDLE;
         cnt_q    <= {CNT_W{1'b0}};
         tot_q    <= {CNT_W{1'b0}};
      end else begin
         if (state_q != ST_IDLE)
            tot_q <= tot_q + 1'b1;
         case (state_q)
            ST_IDLE: begin
               if (start && state_q == ST_IDLE) begin
                  state_q  <= SERIAL_VARIANT ? ST_PU : ST_SETTLE;
                  pu_hit_q <= 2'h0;
               end
            end
            ST_SETTLE: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == DISABLE_SETTLE[CNT_W-1:0] - 1'b1) begin
                  cnt_q   <= {CNT_W{1'b0}};
                  state_q <= ST_PU;
               end
            end
            ST_PU: begin
               cnt_q <= cnt_q + 1'b1;
               if (phase_end(cnt_q)) begin
                  pu_hit_q <= pu_s;
                  cnt_q    <= {CNT_W{1'b0}};
                  state_q  <= ST_PD;
               end
            end
            ST_PD: begin
               cnt_q <= cnt_q + 1'b1;
               if (phase_end(cnt_q)) begin
                  cnt_q   <= {CNT_W{1'b0}};
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: state_q <= ST_WAIT;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // open flags from both comparators; set wins over clear
   wire [1:0] open_set = (state_q == ST_PD && phase_end(cnt_q) && !abort)
                         ? (pu_hit_q & pd_s) : 2'h0;
   // one latch per output; a set in the cycle of a clear still latches
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_open
         reg flag_q;
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n)
               flag_q <= 1'b0;
            else if (open_set[gi])
               flag_q <= 1'b1;
            else if (clear_cmd)
               flag_q <= 1'b0;
         end
         assign open_flag_q[gi] = flag_q;
      end
   endgenerate

   // active open counter on pwm cycle ends
   // the counter saturates so a long open run cannot wrap and re-arm
   wire active_on = active_open_enable_q && !(!SERIAL_VARIANT && cfg_high_q);
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ola_cnt_q     <= 2'h0;
         active_open_q <= 1'b0;
      end else begin
         if (!active_on)
            ola_cnt_q <= 2'h0;
         else if (pwm_cycle_end) begin
            if (overshoot_seen)
               ola_cnt_q <= 2'h0;
            else if (ola_cnt_q != `ACTIVE_OPEN_COUNT)
               ola_cnt_q <= ola_cnt_q + 1'b1;
         end
         if (active_on && pwm_cycle_end && !overshoot_seen && ola_cnt_q == `ACTIVE_OPEN_COUNT - 1'b1)
            active_open_q <= 1'b1;
         else if (clear_cmd)
            active_open_q <= 1'b0;
      end
   end

   // thermal shutdown, always armed
   // hot wins over any clear, so a clear while still hot keeps the bridge off
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overtemp_flag_q <= 1'b0;
         overtemp_off_q  <= 1'b0;
      end else begin
         if (hot_s)
            overtemp_flag_q <= 1'b1;
         else if (clear_cmd)
            overtemp_flag_q <= 1'b0;
         if (hot_s)
            overtemp_off_q <= 1'b1;
         else if (overtemp_recovery_sel_q ? cool_s : (cool_s && clear_cmd))
            overtemp_off_q <= 1'b0;
      end
   end

   wire any_fault = (|open_flag_q) || active_open_q || overtemp_off_q;

   // analog controls from flops
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pullup_source_en   <= 2'h0;
         pulldown_source_en <= 2'h0;
         bridge_enable      <= 1'b0;
         high_side_recirc   <= 1'b1;
         charge_pump_en     <= 1'b0;
      end else begin
         pullup_source_en   <= (state_q == ST_PU) ? 2'h3 : 2'h0;
         pulldown_source_en <= (state_q == ST_PD) ? 2'h3 : 2'h0;
         bridge_enable      <= (state_q == ST_IDLE) && !overtemp_off_q && !dis_s && sleep_s;
         high_side_recirc   <= (control_mode != 2'h2);
         charge_pump_en     <= sleep_s;
      end
   end

   // error pin drives low while an open flag, the active open flag or the thermal shutdown is set
   // the pin is only ever pulled low; the board pull-up gives the high level
   reg err_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         err_q <= 1'b0;
      else
         err_q <= any_fault;
   end
   assign error_pin_n_o  = 1'b0;
   assign error_pin_n_oe = err_q;

   // status word, assembled once for the read port
   wire [7:0] status_word;
   assign status_word[7:6]                   = 2'h0;
   assign status_word[`ST_PASSIVE_BUSY_BIT]  = (state_q != ST_IDLE);
   assign status_word[`ST_ACTIVE_OPEN_BIT]   = active_open_q;
   assign status_word[`ST_OVERTEMP_BIT]      = overtemp_flag_q;
   assign status_word[`ST_OUT2_OPEN_BIT]     = open_flag_q[1];
   assign status_word[`ST_OUT1_OPEN_BIT]     = open_flag_q[0];
   assign status_word[`ST_FAULT_BIT]         = any_fault | overtemp_flag_q;

   // read port, data one cycle after the strobe
   // data return to zero outside the answer cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rdata <= 8'h00;
      else if (rd) begin
         case (addr)
            `CONTROL_REG_ONE_ADDR:   rdata <= {7'h00, passive_open_enable_q};
            `CONTROL_REG_THREE_ADDR: rdata <= {6'h00, overtemp_recovery_sel_q, 1'b0};
            `CONTROL_REG_FOUR_ADDR:  rdata <= {7'h00, active_open_enable_q};
            `STATUS_REG_ADDR:        rdata <= status_word;
            default:                 rdata <= 8'h00;
         endcase
      end else
         rdata <= 8'h00;
   end

endmodule
`default_nettype wire

// [open_fault_props.sv]
// port checker of the open-load and thermal fault logic
`timescale 1ns/1ns
`default_nettype none
module open_fault_props (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // host pins and analog inputs
   input wire logic       disable_pin,
   input wire logic       sleep_pin_n,
   input wire logic       motor_energized,
   input wire logic [1:0] control_mode,
   input wire logic       overtemp_hot,
   // analog controls and error pin
   input wire logic [1:0] pullup_source_en,
   input wire logic [1:0] pulldown_source_en,
   input wire logic       bridge_enable,
   input wire logic       high_side_recirc,
   input wire logic       charge_pump_en,
   input wire logic       error_pin_n_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // some test source is switched on
   wire logic test_on = (pullup_source_en != 2'h0) || (pulldown_source_en != 2'h0);
   // the repeat counts leave room for the two sync flops plus the output register
   bridge_off_test_a: assert property (test_on |-> !bridge_enable) else $error("bridge on in open test");
   phase_order_a: assert property ($rose(pulldown_source_en != 2'h0) |-> $past(pullup_source_en != 2'h0))
      else $error("pull-down phase without pull-up phase");
   phase_excl_a: assert property (!((pullup_source_en != 2'h0) && (pulldown_source_en != 2'h0)))
      else $error("both sources on");
   abort_disable_a: assert property (!disable_pin [*5] |-> !test_on) else $error("test runs with pin low");
   energized_block_a: assert property (motor_energized [*3] |-> !test_on) else $error("test while energized");
   overtemp_off_a: assert property (overtemp_hot [*6] |-> !bridge_enable && error_pin_n_oe)
      else $error("no shutdown on overtemp");
   pump_fault_a: assert property ($rose(error_pin_n_oe) |-> charge_pump_en) else $error("pump off in fault");
   recirc_mode_a: assert property ((control_mode != 2'h2) |=> high_side_recirc) else $error("no high-side decay");
   sleep_clear_a: assert property (!sleep_pin_n [*5] |-> !error_pin_n_oe && !charge_pump_en)
      else $error("fault kept in sleep");
endmodule
bind open_fault_logic open_fault_props u_props (.clk(clk), .rst_n(rst_n), .disable_pin(disable_pin),
   .sleep_pin_n(sleep_pin_n), .motor_energized(motor_energized), .control_mode(control_mode),
   .overtemp_hot(overtemp_hot), .pullup_source_en(pullup_source_en), .pulldown_source_en(pulldown_source_en),
   .bridge_enable(bridge_enable), .high_side_recirc(high_side_recirc), .charge_pump_en(charge_pump_en),
   .error_pin_n_oe(error_pin_n_oe));
`default_nettype wire

// [host_side_model.sv]
// host side model: control pins and the pulled-up error line
`timescale 1ns/1ns
`default_nettype none
module host_side_model (
   // clock
   input  wire logic clk,
   // requests from the bench
   input  wire logic want_dis,
   input  wire logic want_slp_n,
   // device error pin
   input  wire logic error_pin_n_o,
   input  wire logic error_pin_n_oe,
   // pins towards the device
   output var logic  disable_pin,
   output var logic  sleep_pin_n,
   output wire logic error_line
);
   // pins start disabled and awake, then move right after an edge
   initial begin
      disable_pin = 1'b1;
      sleep_pin_n = 1'b1;
   end
   always @(posedge clk) begin
      disable_pin <= want_dis;
      sleep_pin_n <= want_slp_n;
   end
   // pull-up wins while nobody pulls the line down
   assign error_line = error_pin_n_oe ? error_pin_n_o : 1'b1;
endmodule
`default_nettype wire

// [open_fault_logic_tb_top.sv]
// self-checking bench of the open-load and thermal fault logic
`timescale 1ns/1ns
`default_nettype none
`include "open_fault_regs.vh"
module open_fault_logic_tb_top;
   localparam int         SETTLE = 4;
   localparam int         DUR    = 40;
   localparam int         PH     = 8;
   localparam logic [3:0] reg1_a = `CONTROL_REG_ONE_ADDR;
   localparam logic [3:0] reg3_a = `CONTROL_REG_THREE_ADDR;
   localparam logic [3:0] reg4_a = `CONTROL_REG_FOUR_ADDR;
   localparam logic [3:0] stat_a = `STATUS_REG_ADDR;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       want_dis = 1'b1;
   logic       want_slp_n = 1'b1;
   logic       motor = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [1:0] pu = 2'h0;
   logic [1:0] pd = 2'h0;
   logic       pwm_end = 1'b0;
   logic       ovs = 1'b0;
   logic       hot = 1'b0;
   logic       cool = 1'b1;
   logic       cfg_n = 1'b1;
   wire logic [1:0] pu_en_p;
   wire logic [1:0] pd_en_p;
   wire logic [7:0] rdata;
   wire logic [1:0] pu_en;
   wire logic [1:0] pd_en;
   wire logic       bridge;
   wire logic       hsr;
   wire logic       pump;
   wire logic       err_o;
   wire logic       err_oe;
   wire logic       disable_pin;
   wire logic       sleep_pin_n;
   wire logic       error_line;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   // clock and timeout
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         tally_and_finish;
      end
   end
   open_fault_logic #(.DISABLE_SETTLE(SETTLE), .TEST_DURATION(DUR), .PHASE_LEN(PH)) dut (.clk(clk), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .disable_pin(disable_pin),
      .sleep_pin_n(sleep_pin_n), .open_load_cfg_pin_n(cfg_n), .motor_energized(motor), .control_mode(mode),
      .pullup_open_comparator(pu), .pulldown_open_comparator(pd), .pwm_cycle_end(pwm_end), .overshoot_seen(ovs),
      .overtemp_hot(hot), .overtemp_cool(cool), .pullup_source_en(pu_en), .pulldown_source_en(pd_en),
      .bridge_enable(bridge), .high_side_recirc(hsr), .charge_pump_en(pump), .error_pin_n_o(err_o),
      .error_pin_n_oe(err_oe));
   // pin variant beside the serial one, sharing every input
   open_fault_logic #(.SERIAL_VARIANT(0), .DISABLE_SETTLE(SETTLE), .TEST_DURATION(DUR), .PHASE_LEN(PH)) dut_pin (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(), .disable_pin(disable_pin),
      .sleep_pin_n(sleep_pin_n), .open_load_cfg_pin_n(cfg_n), .motor_energized(motor), .control_mode(mode),
      .pullup_open_comparator(pu), .pulldown_open_comparator(pd), .pwm_cycle_end(pwm_end), .overshoot_seen(ovs),
      .overtemp_hot(hot), .overtemp_cool(cool), .pullup_source_en(pu_en_p), .pulldown_source_en(pd_en_p),
      .bridge_enable(), .high_side_recirc(), .charge_pump_en(), .error_pin_n_o(), .error_pin_n_oe());
   host_side_model host (.clk(clk), .want_dis(want_dis), .want_slp_n(want_slp_n), .error_pin_n_o(err_o),
      .error_pin_n_oe(err_oe), .disable_pin(disable_pin), .sleep_pin_n(sleep_pin_n), .error_line(error_line));
   task automatic tally_and_finish;
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic pwm(input logic ov);
      @(posedge clk);
      pwm_end <= 1'b1;
      ovs <= ov;
      @(posedge clk);
      pwm_end <= 1'b0;
   endtask
   task automatic t_reset;
      rchk(stat_a, 8'h00);
      rchk(reg1_a, 8'h00);
      rchk(reg4_a, 8'h00);
      rchk(4'hf, 8'h00);
   endtask
   task automatic t_clean;
      cyc(SETTLE);
      wreg(reg1_a, 8'h01);
      rchk(reg1_a, 8'h01);
      chk(8'(pu_en), 8'h03);
      chk(8'(bridge), 8'h00);
      cyc(DUR + 10);
      rchk(reg1_a, 8'h00);
      rchk(stat_a, 8'h00);
   endtask
   task automatic t_open;
      @(posedge clk);
      pu <= 2'h1;
      pd <= 2'h1;
      cyc(SETTLE);
      wreg(reg1_a, 8'h01);
      cyc(DUR + 10);
      rchk(stat_a, 8'h03);
      chk(8'(error_line), 8'h00);
      chk(8'(pump), 8'h01);
      pu <= 2'h0;
      pd <= 2'h0;
      cyc(3);
      wreg(reg3_a, 8'h01);
      cyc(2);
      rchk(stat_a, 8'h00);
      chk(8'(error_line), 8'h01);
   endtask
   task automatic t_abort;
      @(posedge clk);
      pu <= 2'h3;
      pd <= 2'h3;
      cyc(SETTLE);
      wreg(reg1_a, 8'h01);
      cyc(4);
      want_dis <= 1'b0;
      cyc(DUR + 10);
      rchk(stat_a, 8'h00);
      rchk(reg1_a, 8'h00);
      chk(8'(bridge), 8'h01);
      @(posedge clk);
      pu <= 2'h0;
      pd <= 2'h0;
      want_dis <= 1'b1;
   endtask
   task automatic t_motor;
      cyc(SETTLE);
      motor <= 1'b1;
      wreg(reg1_a, 8'h01);
      cyc(4);
      chk(8'(pu_en), 8'h00);
      rchk(reg1_a, 8'h00);
   endtask
   task automatic t_active;
      @(posedge clk);
      want_dis <= 1'b0;
      mode <= 2'h2;
      cyc(4);
      chk(8'(hsr), 8'h00);
      mode <= 2'h1;
      cyc(2);
      chk(8'(hsr), 8'h01);
      pwm(1'b0);
      pwm(1'b0);
      pwm(1'b0);
      rchk(stat_a, 8'h00);
      wreg(reg4_a, 8'h01);
      pwm(1'b0);
      pwm(1'b0);
      pwm(1'b1);
      pwm(1'b0);
      pwm(1'b0);
      rchk(stat_a, 8'h00);
      pwm(1'b0);
      rchk(stat_a, 8'h11);
      chk(8'(error_line), 8'h00);
      wreg(reg4_a, 8'h00);
      wreg(reg3_a, 8'h01);
      rchk(stat_a, 8'h00);
   endtask
   task automatic t_thermal;
      @(posedge clk);
      hot <= 1'b1;
      cool <= 1'b0;
      cyc(6);
      chk(8'(bridge), 8'h00);
      chk(8'(error_line), 8'h00);
      chk(8'(pump), 8'h01);
      hot <= 1'b0;
      cool <= 1'b1;
      cyc(6);
      chk(8'(bridge), 8'h00);
      wreg(reg3_a, 8'h01);
      cyc(3);
      chk(8'(bridge), 8'h01);
      rchk(stat_a, 8'h00);
      wreg(reg3_a, 8'h02);
      @(posedge clk);
      hot <= 1'b1;
      cool <= 1'b0;
      cyc(6);
      chk(8'(bridge), 8'h00);
      hot <= 1'b0;
      cool <= 1'b1;
      cyc(6);
      chk(8'(bridge), 8'h01);
      chk(8'(error_line), 8'h01);
      rchk(stat_a, 8'h09);
   endtask
   task automatic t_sleep;
      wreg(reg4_a, 8'h01);
      @(posedge clk);
      want_slp_n <= 1'b0;
      cyc(6);
      chk(8'(pump), 8'h00);
      want_slp_n <= 1'b1;
      cyc(6);
      rchk(stat_a, 8'h00);
      rchk(reg4_a, 8'h00);
      chk(8'(error_line), 8'h01);
   endtask
   task automatic t_pin;
      motor <= 1'b0;
      want_dis <= 1'b1;
      cfg_n <= 1'b0;
      cyc(4);
      want_slp_n <= 1'b0;
      cyc(4);
      want_slp_n <= 1'b1;
      cyc(12);
      chk(8'(pu_en_p), 8'h03);
      chk(8'(pu_en), 8'h00);
      cfg_n <= 1'b1;
      want_slp_n <= 1'b0;
      cyc(4);
      want_slp_n <= 1'b1;
      cyc(12);
      chk(8'(pu_en_p | pd_en_p), 8'h00);
   endtask
   // reset, let the sleep pin sync, then run every scenario
   initial begin
      cyc(10);
      rst_n <= 1'b1;
      cyc(4);
      t_reset;
      t_clean;
      t_open;
      t_abort;
      t_motor;
      t_active;
      t_thermal;
      t_sleep;
      t_pin;
      tally_and_finish;
   end
endmodule
`default_nettype wire
